// File: rtl/btsu_bit_test_skip_unit.sv
// Top of the bit test and skip unit: decode, register read, test and skip.
//****************************************************************
//****************************************************************
`timescale 1ns/100ps
module btsu_bit_test_skip_unit
    import btsu_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [INSTR_WIDTH-1:0] instrWord,
    input wire logic instrValid,
    input wire logic [DATA_WIDTH-1:0] regReadData,
    output logic [ADDR_WIDTH-1:0] regReadAddr,
    output logic regReadEnable,
    output logic isBitTest,
    output logic squashNext,
    output logic [INSTR_WIDTH-1:0] execWord,
    output logic cycleBusy,
    output logic regWriteEnable,
    output logic statusWriteEnable
);
    //****************************************************************
    // Local types and signals
    //****************************************************************
    // All registered state of the unit lives in one packed struct.
    // The phase field records the idle cycle after reset and whether the last cycle was a discard.
    typedef struct packed {
        btsu_phase_type phase;
        logic [ADDR_WIDTH-1:0] readAddr;
        logic readEnable;
        logic bitTest;
        logic squash;
        logic [INSTR_WIDTH-1:0] word;
        logic busy;
        logic regWrite;
        logic statusWrite;
    } btsu_state_type;

    btsu_state_type state;
    btsu_state_type next_state;

    // Views of the decoded word.
    logic wordIsClearTest;
    logic wordIsSetTest;
    logic wordIsBitTest;
    logic [SEL_WIDTH-1:0] wordBitSel;
    logic [ADDR_WIDTH-1:0] wordRegAddr;

    // Test and skip terms.
    logic [DATA_WIDTH-1:0] bitPick;
    logic testedBit;
    logic clearHolds;
    logic setHolds;
    logic skipTaken;
    logic discardWord;

    btsu_dec_if dec();

    //****************************************************************
    // Decoder
    //****************************************************************
    // The decoder is purely combinational; its fields are read in the same cycle.
    btsu_decoder decoderInst (
        .instrWord(instrWord),
        .instrValid(instrValid),
        .dec(dec)
    );

    // The decoder already folds instrValid into both opcode flags.
    always_comb begin
        wordIsClearTest = dec.isClear;
        wordIsSetTest = dec.isSet;
        wordIsBitTest = dec.isClear || dec.isSet;
        wordBitSel = dec.bitSel;
        wordRegAddr = dec.regAddr;
    end

    //****************************************************************
    // Bit selection
    //****************************************************************
    // One gate per data bit; only the bit named by the select field can be high.
    // A one-hot pick avoids a wide variable index in the test path.
    generate
        for (genvar b = 0; b < DATA_WIDTH; b++) begin : gen_bit_pick
            assign bitPick[b] = regReadData[b] && (wordBitSel == SEL_WIDTH'(b));
        end
    endgenerate

    //****************************************************************
    // Test
    //****************************************************************
    // The register read is combinational, so the test resolves in the decode cycle itself.
    // Trade-off: the register file read sits on the decode path, in exchange for no stall.
    // At most one of the two conditions can hold, since the opcodes differ.
    always_comb begin
        testedBit = |bitPick;
        clearHolds = wordIsClearTest && !testedBit;
        setHolds = wordIsSetTest && testedBit;
        skipTaken = clearHolds || setHolds;
    end

    //****************************************************************
    // Discard
    //****************************************************************
    // The word arriving while a skip is pending is the one to be thrown away.
    // Only one word is ever dropped per skip.
    always_comb begin
        discardWord = state.squash;
    end

    //****************************************************************
    // Next state
    //****************************************************************
    always_comb begin
        // Defaults: pass the word through and drop every one-cycle pulse.
        next_state = state;
        next_state.readAddr = wordRegAddr;
        next_state.readEnable = wordIsBitTest;
        next_state.bitTest = wordIsBitTest;
        next_state.squash = 1'b0;
        next_state.busy = 1'b0;
        next_state.word = instrWord;

        // A bit test only ever reads; the write strobes stay low.
        next_state.regWrite = 1'b0;
        next_state.statusWrite = 1'b0;

        case (state.phase)
            // Leaving reset behaves like any other cycle.
            BTSU_IDLE: begin
                if (discardWord) begin
                    next_state.word = NO_OPERATION_WORD;
                    next_state.readEnable = 1'b0;
                    next_state.bitTest = 1'b0;
                    next_state.phase = BTSU_SQUASH;
                end else if (skipTaken) begin
                    next_state.squash = 1'b1;
                    next_state.busy = 1'b1;
                    next_state.phase = BTSU_EXEC;
                end else begin
                    next_state.phase = BTSU_EXEC;
                end
            end
            BTSU_EXEC: begin
                // The dropped word is never tested, so a skip cannot chain into a second one.
                if (discardWord) begin
                    next_state.word = NO_OPERATION_WORD;
                    next_state.readEnable = 1'b0;
                    next_state.bitTest = 1'b0;
                    next_state.phase = BTSU_SQUASH;
                end else if (skipTaken) begin
                    next_state.squash = 1'b1;
                    next_state.busy = 1'b1;
                    next_state.phase = BTSU_EXEC;
                end else begin
                    next_state.phase = BTSU_EXEC;
                end
            end
            // The word after a discard is tested as usual.
            BTSU_SQUASH: begin
                if (skipTaken) begin
                    next_state.squash = 1'b1;
                    next_state.busy = 1'b1;
                end
                next_state.phase = BTSU_EXEC;
            end
            default: begin
                next_state.phase = BTSU_IDLE;
            end
        endcase

        // An invalid slot never raises the read or test strobes.
        if (!instrValid) begin
            next_state.readEnable = 1'b0;
            next_state.bitTest = 1'b0;
        end
    end

    //****************************************************************
    // Registers
    //****************************************************************
    // Reset puts no_operation on the execute word so nothing runs before the first fetch.
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state.phase <= BTSU_IDLE;
            state.readAddr <= ADDR_RESET;
            state.readEnable <= 1'b0;
            state.bitTest <= 1'b0;
            state.squash <= 1'b0;
            state.word <= NO_OPERATION_WORD;
            state.busy <= 1'b0;
            state.regWrite <= 1'b0;
            state.statusWrite <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    //****************************************************************
    // Outputs
    //****************************************************************
    // Every output is a field of the registered state.
    assign regReadAddr = state.readAddr;
    assign regReadEnable = state.readEnable;
    assign isBitTest = state.bitTest;
    assign squashNext = state.squash;
    assign execWord = state.word;
    assign cycleBusy = state.busy;

    // The write strobes are registered like the rest, so no output comes from a constant.
    assign regWriteEnable = state.regWrite;
    assign statusWriteEnable = state.statusWrite;
endmodule

// File: rtl/btsu_pkg.sv
// Package with the encodings and field layout of the bit test and skip unit.
package btsu_pkg;
    localparam int INSTR_WIDTH = 12;
    localparam int DATA_WIDTH = 8;
    localparam int ADDR_WIDTH = 5;
    localparam int SEL_WIDTH = 3;
    localparam int OPC_MSB = 11;
    localparam int OPC_LSB = 8;
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 5;
    localparam int ADDR_MSB = 4;
    localparam int ADDR_LSB = 0;
    localparam logic [3:0] OPC_SKIP_WHEN_CLEAR = 4'h6;
    localparam logic [3:0] OPC_SKIP_WHEN_SET = 4'h7;
    localparam logic [11:0] NO_OPERATION_WORD = 12'h000;
    localparam logic [4:0] ADDR_RESET = 5'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef enum logic [1:0] {
        BTSU_IDLE,
        BTSU_EXEC,
        BTSU_SQUASH
    } btsu_phase_type;
endpackage

// File: rtl/btsu_dec_if.sv
// Interface carrying decoded fields from the decoder to the execute stage.
`timescale 1ns/100ps
interface btsu_dec_if;
    logic isClear;
    logic isSet;
    logic [2:0] bitSel;
    logic [4:0] regAddr;
    modport source (output isClear, output isSet, output bitSel, output regAddr);
    modport sink (input isClear, input isSet, input bitSel, input regAddr);
endinterface

// File: rtl/btsu_decoder.sv
// Combinational decoder for the two bit test and skip instruction words.
`timescale 1ns/100ps
module btsu_decoder
    import btsu_pkg::*;
(
    input wire logic [INSTR_WIDTH-1:0] instrWord,
    input wire logic instrValid,
    btsu_dec_if.source dec
);
    always_comb begin
        dec.isClear = instrValid && (instrWord[OPC_MSB:OPC_LSB] == OPC_SKIP_WHEN_CLEAR);
        dec.isSet = instrValid && (instrWord[OPC_MSB:OPC_LSB] == OPC_SKIP_WHEN_SET);
        dec.bitSel = instrWord[SEL_MSB:SEL_LSB];
        dec.regAddr = instrWord[ADDR_MSB:ADDR_LSB];
    end
endmodule

// File: verification/btsu_chk.sv
// Checker of the bit test and skip unit ports.
`timescale 1ns/100ps
module btsu_chk
    import btsu_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [INSTR_WIDTH-1:0] instrWord,
    input wire logic instrValid,
    input wire logic [DATA_WIDTH-1:0] regReadData,
    input wire logic [ADDR_WIDTH-1:0] regReadAddr,
    input wire logic regReadEnable,
    input wire logic isBitTest,
    input wire logic squashNext,
    input wire logic [INSTR_WIDTH-1:0] execWord,
    input wire logic cycleBusy,
    input wire logic regWriteEnable,
    input wire logic statusWriteEnable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // The word after a taken skip is discarded, so it must never count as live.
    wire logic live = instrValid && !squashNext;
    wire logic bitVal = regReadData[instrWord[7:5]];
    wire logic [3:0] opc = instrWord[11:8];
    clr_skip_a: assert property (live && opc == 4'h6 && !bitVal |=> squashNext)
        else $error("Clear test did not skip.");
    set_skip_a: assert property (live && opc == 4'h7 && bitVal |=> squashNext)
        else $error("Set test did not skip.");
    no_skip_a: assert property (
        !(live && (opc == 4'h6 && !bitVal || opc == 4'h7 && bitVal)) |=> !squashNext)
        else $error("Skip without cause.");
    test_seen_a: assert property (live && opc[3:1] == 3'b011 |=>
        isBitTest && regReadEnable && regReadAddr == $past(instrWord[4:0]))
        else $error("Bit test not decoded.");
    nop_sub_a: assert property (squashNext |=> execWord == 12'h000)
        else $error("Discarded word was executed.");
    two_cycle_a: assert property (squashNext |-> cycleBusy ##1 !squashNext)
        else $error("Skip length wrong.");
    pass_word_a: assert property (live |=> execWord == $past(instrWord))
        else $error("Word not passed on.");
    no_write_a: assert property (!regWriteEnable && !statusWriteEnable)
        else $error("Register or status written.");
    cover property (squashNext);
    cover property (isBitTest && !squashNext);
    cover property (isBitTest ##1 isBitTest);
endmodule
bind btsu_bit_test_skip_unit btsu_chk btsu_chk_inst (.*);

// File: verification/test_bit_test_skip_unit.sv
// Self-checking bench for the bit test and skip unit.
`timescale 1ns/100ps
module test_bit_test_skip_unit import btsu_pkg::*;;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [INSTR_WIDTH-1:0] instrWord = 12'h000;
    logic instrValid = 1'b0;
    logic [DATA_WIDTH-1:0] regReadData = 8'h00;
    logic [ADDR_WIDTH-1:0] regReadAddr;
    logic regReadEnable, isBitTest, squashNext, cycleBusy, regWriteEnable, statusWriteEnable;
    logic [INSTR_WIDTH-1:0] execWord;
    integer seed = 32'h1D59;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    logic expSquash = 1'b0;
    logic expValid, expTest;
    // Skip at bit 7, then a discarded set test that would also skip.
    logic [19:0] corner [2] = '{20'h6E07F, 20'h70001};
    btsu_bit_test_skip_unit btsu_bit_test_skip_unit_inst (
        .clock(clock),
        .resetn(resetn),
        .instrWord(instrWord),
        .instrValid(instrValid),
        .regReadData(regReadData),
        .regReadAddr(regReadAddr),
        .regReadEnable(regReadEnable),
        .isBitTest(isBitTest),
        .squashNext(squashNext),
        .execWord(execWord),
        .cycleBusy(cycleBusy),
        .regWriteEnable(regWriteEnable),
        .statusWriteEnable(statusWriteEnable)
    );
    //****************
    // Helpers
    //****************
    function automatic logic takesSkip(input logic [11:0] w, input logic [7:0] d);
        return w[11:8] == 4'h6 && !d[w[7:5]] || w[11:8] == 4'h7 && d[w[7:5]];
    endfunction
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            errors++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        #5 check(squashNext, 1'b0);
        check(execWord, 12'h000);
        #5 resetn = 1'b1;
        for (int i = 0; i < 400; i++) begin
            instrWord = 12'($random(seed));
            if (i % 4 != 3) instrWord[11:9] = 3'b011;
            instrValid = (i % 8) != 5;
            regReadData = 8'($random(seed));
            if (i < 2) {instrWord, regReadData} = corner[i];
            expValid = instrValid && !expSquash;
            expTest = expValid && instrWord[11:9] == 3'b011;
            @(posedge clock);
            #5 if (expSquash || instrValid) check(execWord, expSquash ? 12'h000 : instrWord);
            expSquash = expValid && takesSkip(instrWord, regReadData);
            check(squashNext, expSquash);
            check(cycleBusy, expSquash);
            check(isBitTest, expTest);
            check(regReadEnable, expTest);
            if (expTest) check(regReadAddr, instrWord[4:0]);
            check(regWriteEnable | statusWriteEnable, 1'b0);
            #5;
        end
        results();
    end
endmodule
